// *** shared/uga_params.svh ***
`ifndef UGA_PARAMS_SVH
`define UGA_PARAMS_SVH
// Timing in clock cycles at 40 MHz unless noted; EXTRA_PERIOD counts grants, the last four are counts
`define UGA_CLK_HZ            40000000
`define UGA_INTERVAL_US       10000
`define UGA_INTERVAL_CYC      ((`UGA_INTERVAL_US * (`UGA_CLK_HZ / 1000000)))
`define UGA_IDLE_US           40000
`define UGA_IDLE_CYC          ((`UGA_IDLE_US * (`UGA_CLK_HZ / 1000000)))
`define UGA_JITTER_CYC        2000
`define UGA_EXTRA_PERIOD      100
`define UGA_BURST_GRANTS      2
`define UGA_MAX_GPI           4
`define UGA_NUM_SUBFLOWS      4
`define UGA_QUEUE_HI          2
// Register offsets in the headend register window (APB, byte addresses)
`define UGA_REG_CTRL          12'h000
`define UGA_REG_STATUS        12'h004
`define UGA_REG_COUNT         12'h008
// Control field positions
`define UGA_CTRL_EN_BIT       0
`define UGA_CTRL_AD_BIT       1
`define UGA_CTRL_RESET        32'h00000003
`endif

// *** shared/uga_pkg.sv ***
package uga_pkg;
  typedef enum logic [1:0] {
    UGA_OP_NONE,
    UGA_OP_GRANT,
    UGA_OP_POLL
  } uga_op_t;
  typedef enum logic [1:0] {
    UGA_UP_NONE,
    UGA_UP_DATA,
    UGA_UP_REQ
  } uga_up_t;
endpackage

// *** shared/uga_link_if.sv ***
`timescale 1ns/1ps
interface uga_link_if;
  import uga_pkg::*;
  // Headend to modem opportunity
  logic        opp_valid;
  uga_op_t     opp_kind;
  // Modem to headend upstream answer in that opportunity
  logic        up_valid;
  uga_up_t     up_kind;
  logic [7:0]  up_active_grants;
  logic        up_queue_ind;
  modport modem (
    input  opp_valid,
    input  opp_kind,
    output up_valid,
    output up_kind,
    output up_active_grants,
    output up_queue_ind
  );
  modport headend (
    output opp_valid,
    output opp_kind,
    input  up_valid,
    input  up_kind,
    input  up_active_grants,
    input  up_queue_ind
  );
endinterface

// *** hw/uga_act_timer.sv ***
`timescale 1ns/1ps
`include "uga_params.svh"
module uga_act_timer #(
  parameter int IDLE_CYC = `UGA_IDLE_CYC
) (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic pkt,
  output logic      active
);
  import uga_pkg::*;
  typedef struct packed {
    logic [31:0] cnt;
    logic        act;
  } uga_tmr_st_t;
  uga_tmr_st_t s_q;
  uga_tmr_st_t s_d;
  always_comb
  begin
    s_d = s_q;
    if (pkt)
    begin
      s_d.act = 1'b1;
      s_d.cnt = 32'(IDLE_CYC);
    end
    else if (s_q.cnt != 32'h0)
    begin
      s_d.cnt = s_q.cnt - 32'h1;
      if (s_q.cnt == 32'h1)
      begin
        s_d.act = 1'b0;
      end
    end
  end
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  assign active = s_q.act;
endmodule

// *** hw/uga_modem.sv ***
`timescale 1ns/1ps
`include "uga_params.svh"
module uga_modem #(
  parameter int NUM_SUB  = `UGA_NUM_SUBFLOWS,
  parameter int MAX_GPI  = `UGA_MAX_GPI,
  parameter int IDLE_CYC = `UGA_IDLE_CYC,
  parameter int QUEUE_HI = `UGA_QUEUE_HI
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  uga_link_if.modem         link,
  input  wire logic [NUM_SUB-1:0] sub_pkt,
  input  wire logic [7:0]   max_gpi,
  output logic [7:0]        needed_grants,
  output logic [7:0]        queue_depth,
  output logic              talking
);
  import uga_pkg::*;
  typedef struct packed {
    logic        talking;
    logic        zero_due;
    logic [7:0]  queue;
    logic        up_valid;
    uga_up_t     up_kind;
    logic [7:0]  up_active;
    logic        up_qi;
  } uga_modem_st_t;
  uga_modem_st_t s_q;
  uga_modem_st_t s_d;
  logic [NUM_SUB-1:0] sub_act;
  logic [7:0]         act_count;
  logic [7:0]         pkt_count;
  logic [7:0]         cap;
  logic [7:0]         req_count;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SUB; gi++)
    begin : g_tmr
      uga_act_timer #(
        .IDLE_CYC (IDLE_CYC)
      ) u_tmr (
        .clock  (clock),
        .nrst   (nrst),
        .pkt    (sub_pkt[gi]),
        .active (sub_act[gi])
      );
    end
  endgenerate
  always_comb
  begin
    act_count = 8'h0;
    pkt_count = 8'h0;
    for (int i = 0; i < NUM_SUB; i++)
    begin
      act_count = act_count + {7'h0, sub_act[i] | sub_pkt[i]};
      pkt_count = pkt_count + {7'h0, sub_pkt[i]};
    end
    // Clamp to the smaller of configured and built-in maximum
    cap = (max_gpi < 8'(MAX_GPI)) ? max_gpi : 8'(MAX_GPI);
    req_count = (act_count > cap) ? cap : act_count;
  end
  always_comb
  begin
    s_d = s_q;
    s_d.up_valid = 1'b0;
    s_d.up_kind = UGA_UP_NONE;
    // Pool of packets from all subflows; a data grant takes any one, the zero count grant clears it
    s_d.queue = s_q.queue + pkt_count;
    if (req_count != 8'h0)
    begin
      s_d.talking = 1'b1;
      s_d.zero_due = 1'b0;
    end
    else if (s_q.talking)
    begin
      s_d.talking = 1'b0;
      s_d.zero_due = 1'b1;
    end
    if (link.opp_valid)
    begin
      if (link.opp_kind == UGA_OP_GRANT)
      begin
        if (req_count != 8'h0)
        begin
          s_d.up_valid = 1'b1;
          s_d.up_kind = UGA_UP_DATA;
          s_d.up_active = req_count;
          if (s_d.queue != 8'h0)
          begin
            s_d.queue = s_d.queue - 8'h1;
          end
        end
        else if (s_q.zero_due)
        begin
          s_d.up_valid = 1'b1;
          s_d.up_kind = UGA_UP_DATA;
          s_d.up_active = 8'h0;
          s_d.zero_due = 1'b0;
          s_d.queue = 8'h0;
        end
      end
      else if (link.opp_kind == UGA_OP_POLL && req_count != 8'h0)
      begin
        s_d.up_valid = 1'b1;
        s_d.up_kind = UGA_UP_REQ;
        s_d.up_active = 8'h1;
      end
    end
    s_d.up_qi = (s_d.queue >= 8'(QUEUE_HI));
  end
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      s_q <= '{talking: 1'b0, zero_due: 1'b0, queue: 8'h0, up_valid: 1'b0,
               up_kind: UGA_UP_NONE, up_active: 8'h0, up_qi: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end
  assign link.up_valid = s_q.up_valid;
  assign link.up_kind = s_q.up_kind;
  assign link.up_active_grants = s_q.up_active;
  assign link.up_queue_ind = s_q.up_qi;
  assign needed_grants = s_q.up_active;
  assign queue_depth = s_q.queue;
  assign talking = s_q.talking;
endmodule

// *** hw/uga_headend.sv ***
`timescale 1ns/1ps
`include "uga_params.svh"
module uga_headend #(
  parameter int INTERVAL_CYC = `UGA_INTERVAL_CYC,
  parameter int MAX_GPI      = `UGA_MAX_GPI,
  parameter int BURST        = `UGA_BURST_GRANTS,
  parameter int EXTRA_PERIOD = `UGA_EXTRA_PERIOD
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  uga_link_if.headend      link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  import uga_pkg::*;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] tick;
    logic        granting;
    logic [7:0]  gpi;
    logic [7:0]  left;
    logic [7:0]  extra;
    logic [7:0]  grant_cnt;
    logic        opp_valid;
    uga_op_t     opp_kind;
  } uga_he_st_t;
  uga_he_st_t s_q;
  uga_he_st_t s_d;
  logic acc;
  logic mapped;
  assign acc = psel & penable;
  assign mapped = (paddr == `UGA_REG_CTRL) || (paddr == `UGA_REG_STATUS)
               || (paddr == `UGA_REG_COUNT);
  always_comb
  begin
    s_d = s_q;
    s_d.opp_valid = 1'b0;
    s_d.opp_kind = UGA_OP_NONE;
    if (acc && pwrite && paddr == `UGA_REG_CTRL)
    begin
      s_d.ctrl = pwdata;
    end
    if (link.up_valid)
    begin
      if (link.up_kind == UGA_UP_REQ)
      begin
        s_d.granting = 1'b1;
        s_d.gpi = 8'h1;
        s_d.extra = 8'(BURST);
      end
      else if (link.up_kind == UGA_UP_DATA)
      begin
        if (link.up_active_grants == 8'h0)
        begin
          s_d.granting = 1'b0;
        end
        else
        begin
          s_d.granting = 1'b1;
          if (link.up_active_grants > s_q.gpi)
          begin
            s_d.extra = s_q.extra + 8'(BURST);
          end
          s_d.gpi = (link.up_active_grants > 8'(MAX_GPI)) ? 8'(MAX_GPI)
                  : link.up_active_grants;
        end
        if (link.up_queue_ind && s_q.grant_cnt >= 8'(EXTRA_PERIOD))
        begin
          s_d.extra = s_d.extra + 8'h1;
          s_d.grant_cnt = 8'h0;
        end
      end
    end
    if (!s_q.ctrl[`UGA_CTRL_AD_BIT])
    begin
      s_d.granting = 1'b1;
    end
    if (s_q.ctrl[`UGA_CTRL_EN_BIT])
    begin
      if (s_q.tick == 32'(INTERVAL_CYC - 1))
      begin
        s_d.tick = 32'h0;
        s_d.left = s_d.granting ? s_d.gpi + s_d.extra : 8'h1;
        s_d.extra = 8'h0;
      end
      else
      begin
        s_d.tick = s_q.tick + 32'h1;
        if (s_q.left != 8'h0 && !link.up_valid && !s_q.opp_valid)
        begin
          // Opportunities from nominal time, never in consecutive cycles nor during an uplink answer, keep within jitter
          s_d.left = s_q.left - 8'h1;
          s_d.opp_valid = 1'b1;
          s_d.opp_kind = s_q.granting ? UGA_OP_GRANT : UGA_OP_POLL;
          if (s_q.granting && s_q.grant_cnt != 8'hFF)
          begin
            s_d.grant_cnt = s_q.grant_cnt + 8'h1;
          end
        end
      end
    end
  end
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      s_q <= '{ctrl: `UGA_CTRL_RESET, tick: 32'h0, granting: 1'b0,
               gpi: 8'h1, left: 8'h0, extra: 8'h0, grant_cnt: 8'h0,
               opp_valid: 1'b0, opp_kind: UGA_OP_NONE};
    end
    else
    begin
      s_q <= s_d;
    end
  end
  // downstream policing lies outside this block
  // Read data stands in the access cycle, muxed from registered state
  always_comb
  begin
    case (paddr)
      `UGA_REG_CTRL:   prdata = s_q.ctrl;
      `UGA_REG_STATUS: prdata = {15'h0, s_q.granting, s_q.gpi, s_q.extra};
      `UGA_REG_COUNT:  prdata = {24'h0, s_q.grant_cnt};
      default:         prdata = 32'h0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign link.opp_valid = s_q.opp_valid;
  assign link.opp_kind = s_q.opp_kind;
endmodule

// *** test/uga_link_monitor.sv ***
`timescale 1ns/1ps
module uga_link_monitor
  import uga_pkg::*;
#(
  parameter int MAX_GPI      = 4,
  parameter int INTERVAL_CYC = 50
) (
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic       opp_valid,
  input wire uga_op_t    opp_kind,
  input wire logic       up_valid,
  input wire uga_up_t    up_kind,
  input wire logic [7:0] up_active_grants,
  input wire logic       up_queue_ind
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // Cycles since the last opportunity of any kind
  logic [7:0] gap_q;
  always_ff @(posedge clock)
  begin
    if (!nrst || opp_valid)
    begin
      gap_q <= 8'h00;
    end
    else if (gap_q != 8'hFF)
    begin
      gap_q <= gap_q + 8'h01;
    end
  end
  // downstream policing is not visible on this link
  a_opp_periodic: assert property (gap_q <= 8'(INTERVAL_CYC + 4))
    else $error("no opportunity within the nominal interval");
  a_answer_after_opp: assert property (up_valid |-> $past(opp_valid))
    else $error("uplink answer without an opportunity");
  a_data_on_grant: assert property (up_valid && up_kind == UGA_UP_DATA
    |-> $past(opp_kind) == UGA_OP_GRANT) else $error("data sent outside a grant");
  a_req_counts_one: assert property (up_valid && up_kind == UGA_UP_REQ
    |-> $past(opp_kind) == UGA_OP_POLL && up_active_grants == 8'h01)
    else $error("request not in a poll or count not one");
  a_count_limit: assert property (up_valid |-> up_active_grants <= MAX_GPI)
    else $error("active grant count above maximum");
  a_single_zero: assert property (up_valid && up_kind == UGA_UP_DATA
    && up_active_grants == 8'h00 |=> (!(up_valid && up_active_grants == 8'h00))[*8])
    else $error("more than one zero count packet");
  a_up_pulse: assert property (up_valid |=> !up_valid)
    else $error("uplink valid longer than one cycle");
  a_resume_grant: assert property (up_valid && up_kind == UGA_UP_REQ
    |-> ##[1:200] (opp_valid && opp_kind == UGA_OP_GRANT))
    else $error("no grant after resume request");
  a_poll_sparse: assert property (opp_valid && opp_kind == UGA_OP_POLL
    |=> (!(opp_valid && opp_kind == UGA_OP_POLL))[*8]) else $error("polls too close");

  c_zero_packet: cover property (up_valid && up_active_grants == 8'h00);
  c_request: cover property (up_valid && up_kind == UGA_UP_REQ);
  c_queue_flag: cover property (up_valid && up_queue_ind);
endmodule

// *** test/unsolicited_grant_activity_ctrl_tb.sv ***
`timescale 1ns/1ps
`include "uga_params.svh"
module unsolicited_grant_activity_ctrl_tb;
  import uga_pkg::*;
  logic        clock, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  act, burst;
  logic [3:0]  sub_pkt = 4'h0;
  logic [7:0]  max_gpi, cnt;
  int          n_fail, samples_checked;
  int          tick = 0;

  uga_link_if link ();
  uga_modem #(.IDLE_CYC(200)) u_uga_modem (.clock(clock), .nrst(nrst), .link(link.modem),
    .sub_pkt(sub_pkt), .max_gpi(max_gpi), .needed_grants(), .queue_depth(), .talking());
  uga_headend #(.INTERVAL_CYC(50), .EXTRA_PERIOD(4)) u_uga_headend (.clock(clock),
    .nrst(nrst), .link(link.headend), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  uga_link_monitor #(.MAX_GPI(`UGA_MAX_GPI), .INTERVAL_CYC(50)) u_uga_link_monitor (
    .clock(clock), .nrst(nrst),
    .opp_valid(link.opp_valid), .opp_kind(link.opp_kind), .up_valid(link.up_valid),
    .up_kind(link.up_kind), .up_active_grants(link.up_active_grants),
    .up_queue_ind(link.up_queue_ind));

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Periodic packets on active subflows plus optional burst
  always @(posedge clock)
  begin
    tick <= tick + 1;
    sub_pkt <= ((tick % 8 == 0) ? act : 4'h0) | burst;
  end

  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task timeout_hit;
    n_fail++;
    $display("Error %0t: wait timed out", $time);
    conclude();
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clock);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
      timeout_hit();
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Wait for an opportunity (opp=1) or an uplink answer of a kind
  task wait_ev(input logic opp, input logic [1:0] k, input logic zero);
    int i;
    for (i = 0; i < 3000; i++)
    begin
      @(posedge clock);
      #1;
      if (opp ? (link.opp_valid === 1'b1 && link.opp_kind === k)
          : (link.up_valid === 1'b1 && link.up_kind === k
             && (!zero || link.up_active_grants === 8'h00)))
        break;
    end
    if (i == 3000)
      timeout_hit();
    cnt = link.up_active_grants;
  endtask

  task t_regs;
    apb(1'b0, `UGA_REG_CTRL, 32'h0);
    chk(rd, `UGA_CTRL_RESET);
    apb(1'b0, 12'hFF0, 32'h0);
    chk(err, 1'b1);
  endtask

  task t_talk;
    @(posedge clock) act <= 4'h1;
    wait_ev(1'b0, UGA_UP_REQ, 1'b0);
    chk(cnt, 8'h01);
    apb(1'b0, `UGA_REG_STATUS, 32'h0);
    chk(rd[7:0], `UGA_BURST_GRANTS);
    chk(rd[16], 1'b1);
    wait_ev(1'b0, UGA_UP_DATA, 1'b0);
    chk(cnt, 8'h01);
  endtask

  task t_multi;
    @(posedge clock) act <= 4'h7;
    repeat (10) @(posedge clock);
    wait_ev(1'b0, UGA_UP_DATA, 1'b0);
    chk(cnt, 8'h03);
    @(posedge clock) max_gpi <= 8'h02;
    wait_ev(1'b0, UGA_UP_DATA, 1'b0);
    wait_ev(1'b0, UGA_UP_DATA, 1'b0);
    chk(cnt, 8'h02);
  endtask

  task t_queue;
    @(posedge clock) burst <= 4'hF;
    repeat (2) @(posedge clock);
    burst <= 4'h0;
    wait_ev(1'b0, UGA_UP_DATA, 1'b0);
    chk(link.up_queue_ind, 1'b1);
  endtask

  task t_idle;
    @(posedge clock) act <= 4'h0;
    wait_ev(1'b0, UGA_UP_DATA, 1'b1);
    chk(link.up_queue_ind, 1'b0);
    apb(1'b0, `UGA_REG_STATUS, 32'h0);
    chk(rd[16], 1'b0);
    wait_ev(1'b1, UGA_OP_POLL, 1'b0);
    @(posedge clock) act <= 4'h1;
    wait_ev(1'b0, UGA_UP_REQ, 1'b0);
    chk(cnt, 8'h01);
    wait_ev(1'b0, UGA_UP_DATA, 1'b0);
    chk(cnt, 8'h01);
  endtask

  task t_plain;
    apb(1'b1, `UGA_REG_CTRL, 32'h1);
    @(posedge clock) act <= 4'h0;
    wait_ev(1'b0, UGA_UP_DATA, 1'b1);
    apb(1'b0, `UGA_REG_STATUS, 32'h0);
    chk(rd[16], 1'b1);
  endtask

  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    max_gpi = 8'h04;
    act = 4'h0;
    burst = 4'h0;
    n_fail = 0;
    samples_checked = 0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    t_regs();
    t_talk();
    t_multi();
    t_queue();
    t_idle();
    t_plain();
    conclude();
  end
endmodule
